// ===== src/scg_clock_gen.sv
// Sample clock generator: AXI4-Lite registers, rate solver and connector control.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Default mode: synthesizer from internal 40 MHz reference; rate requested in hertz.
// - Rate readback returns the nearest achievable rate, not the raw request.
// - Clock output drives the generated clock on the connector, internal clocking only.
// - No internal rate below 1 kHz is ever generated.
// - Rate ceiling depends on variant: 200k, 500k, 1M or 3M samples per second.
// - Synthesizer enable resets to one; zero selects quartz with plain divider.
// - Quartz mode rate is quartz over one of seventeen fixed divisors.
// - Quartz frequency equals the variant's maximum rate, so divisor one is fastest.
// - Quartz mode still accepts a request; readback is nearest divisor rate.
// - Reference setting zero uses internal reference; nonzero hertz uses the connector.
// - External reference accepted from 1 MHz to 125 MHz inclusive.
// - Synthesizer factors are derived from reference and requested rate automatically.
// - Termination enable switches 50 Ohm in only while the connector is an input.
// - External clock select cleared means internal source; clock output needs it cleared.
module scg_clock_gen
  import scg_pkg::*;
#(
  parameter int VARIANT = 3
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Clock hardware control.
  input  wire logic              sample_clk,
  output scg_synth_cfg_s         synth_cfg,
  output logic [11:0]            quartz_div,
  output logic                   solver_busy,
  // External clock connector.
  input  wire logic              conn_i,
  output logic                   conn_o,
  output logic                   conn_oe,
  output logic                   conn_term_on
);

  // ==========================================================================
  // Register decode.
  localparam logic [31:0] QUARTZ_HZ = variant_max(VARIANT);
  localparam logic [31:0] RATE_MAX  = variant_max(VARIANT);

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'({IDX_SAMPLE_RATE, 2'b00}): reg_sel = 3'h1;
      ADDR_W'({IDX_SYNTH_EN, 2'b00}):    reg_sel = 3'h2;
      ADDR_W'({IDX_EXT_SEL, 2'b00}):     reg_sel = 3'h3;
      ADDR_W'({IDX_CLK_OUT, 2'b00}):     reg_sel = 3'h4;
      ADDR_W'({IDX_TERM_EN, 2'b00}):     reg_sel = 3'h5;
      ADDR_W'({IDX_REF_FREQ, 2'b00}):    reg_sel = 3'h6;
      default:                           reg_sel = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ==========================================================================
  // State.
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic              aw_have_ff, nxt_aw_have;
  logic [31:0]       wdata_ff, nxt_wdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic              w_have_ff, nxt_w_have;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic              rvalid_ff, nxt_rvalid;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [31:0]       rate_req_ff, nxt_rate_req;
  logic              synth_en_ff, nxt_synth_en;
  logic              ext_sel_ff, nxt_ext_sel;
  logic              clk_out_ff, nxt_clk_out;
  logic              term_en_ff, nxt_term_en;
  logic [31:0]       ref_freq_ff, nxt_ref_freq;
  logic              pending_ff, nxt_pending;
  scg_state_e        state_ff, nxt_state;
  logic              launched_ff, nxt_launched;
  logic [31:0]       target_ff, nxt_target;
  logic [31:0]       ref_used_ff, nxt_ref_used;
  logic [31:0]       n_ff, nxt_n;
  logic [31:0]       m_ff, nxt_m;
  logic [31:0]       cand_ff, nxt_cand;
  logic [4:0]        qidx_ff, nxt_qidx;
  logic [4:0]        qbest_ff, nxt_qbest;
  logic [31:0]       achieved_ff, nxt_achieved;
  scg_synth_cfg_s    cfg_ff, nxt_cfg;
  logic [11:0]       qdiv_ff, nxt_qdiv;
  logic              conn_o_ff, nxt_conn_o;
  logic              conn_oe_ff, nxt_conn_oe;
  logic              term_on_ff, nxt_term_on;
  logic              div_start;
  logic [63:0]       div_dividend;
  logic [31:0]       div_divisor;
  logic              div_done;
  logic [63:0]       div_quo;
  logic              wr_fire;
  logic [2:0]        wsel;
  logic [31:0]       wval;
  logic [31:0]       quo32;
  logic              drive_ok;

  scg_divider #(.DW(64), .VW(32)) u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (div_start),
    .dividend (div_dividend),
    .divisor  (div_divisor),
    .done     (div_done),
    .quotient (div_quo)
  );

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    nxt_awaddr   = awaddr_ff;
    nxt_aw_have  = aw_have_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb    = wstrb_ff;
    nxt_w_have   = w_have_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rresp    = rresp_ff;
    nxt_rdata    = rdata_ff;
    nxt_rate_req = rate_req_ff;
    nxt_synth_en = synth_en_ff;
    nxt_ext_sel  = ext_sel_ff;
    nxt_clk_out  = clk_out_ff;
    nxt_term_en  = term_en_ff;
    nxt_ref_freq = ref_freq_ff;
    nxt_pending  = pending_ff;
    nxt_state    = state_ff;
    nxt_launched = launched_ff;
    nxt_target   = target_ff;
    nxt_ref_used = ref_used_ff;
    nxt_n        = n_ff;
    nxt_m        = m_ff;
    nxt_cand     = cand_ff;
    nxt_qidx     = qidx_ff;
    nxt_qbest    = qbest_ff;
    nxt_achieved = achieved_ff;
    nxt_cfg      = cfg_ff;
    nxt_qdiv     = qdiv_ff;
    div_start    = 1'b0;
    div_dividend = 64'h0;
    div_divisor  = 32'h1;
    quo32        = div_quo[31:0];

    // Write channel: address and data are taken independently, in either order.
    if (s_axi_awvalid && !aw_have_ff && !bvalid_ff) begin
      nxt_awaddr  = s_axi_awaddr;
      nxt_aw_have = 1'b1;
    end
    if (s_axi_wvalid && !w_have_ff && !bvalid_ff) begin
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
      nxt_w_have = 1'b1;
    end
    wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    wsel    = reg_sel(awaddr_ff);
    wval    = 32'h0;
    if (wr_fire) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (wsel == 3'h0) ? 2'b10 : 2'b00;
      case (wsel)
        3'h1: begin
          nxt_rate_req = merge(rate_req_ff, wdata_ff, wstrb_ff);
          nxt_pending  = 1'b1;
        end
        3'h2: begin
          if (wstrb_ff[0]) begin
            nxt_synth_en = wdata_ff[0];
            nxt_pending  = 1'b1;
          end
        end
        3'h3: if (wstrb_ff[0]) nxt_ext_sel = wdata_ff[0];
        3'h4: if (wstrb_ff[0]) nxt_clk_out = wdata_ff[0];
        3'h5: if (wstrb_ff[0]) nxt_term_en = wdata_ff[0];
        3'h6: begin
          wval = merge(ref_freq_ff, wdata_ff, wstrb_ff);
          // Out-of-range references are dropped so the solver never divides badly.
          if (wval == 32'h0 || (wval >= REF_MIN_HZ && wval <= REF_MAX_HZ)) begin
            nxt_ref_freq = wval;
            nxt_pending  = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // Read channel.
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = 2'b00;
      case (reg_sel(s_axi_araddr))
        3'h1: nxt_rdata = achieved_ff;
        3'h2: nxt_rdata = {31'h0, synth_en_ff};
        3'h3: nxt_rdata = {31'h0, ext_sel_ff};
        3'h4: nxt_rdata = {31'h0, clk_out_ff};
        3'h5: nxt_rdata = {31'h0, term_en_ff};
        3'h6: nxt_rdata = ref_freq_ff;
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = 2'b10;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end

    // Rate solver.
    case (state_ff)
      ST_IDLE: begin
        if (pending_ff && !wr_fire) begin
          nxt_pending  = 1'b0;
          nxt_launched = 1'b0;
          if (rate_req_ff < MIN_RATE_HZ) begin
            nxt_target = MIN_RATE_HZ;
          end else if (rate_req_ff > RATE_MAX) begin
            nxt_target = RATE_MAX;
          end else begin
            nxt_target = rate_req_ff;
          end
          nxt_ref_used = (ref_freq_ff == 32'h0) ? INT_REF_HZ : ref_freq_ff;
          nxt_qidx     = 5'h00;
          nxt_qbest    = 5'h00;
          nxt_achieved = QUARTZ_HZ;
          nxt_state    = synth_en_ff ? ST_SYN_N : ST_QUARTZ;
        end
      end
      ST_SYN_N: begin
        div_start    = !launched_ff;
        nxt_launched = 1'b1;
        div_dividend = {32'h0, ref_used_ff};
        div_divisor  = PFD_HZ;
        if (div_done) begin
          nxt_n        = quo32;
          nxt_launched = 1'b0;
          nxt_state    = ST_SYN_M;
        end
      end
      ST_SYN_M: begin
        div_start    = !launched_ff;
        nxt_launched = 1'b1;
        div_dividend = {32'h0, target_ff + (PFD_HZ >> 1)};
        div_divisor  = PFD_HZ;
        if (div_done) begin
          nxt_m        = quo32;
          nxt_launched = 1'b0;
          nxt_state    = ST_SYN_R;
        end
      end
      ST_SYN_R: begin
        div_start    = !launched_ff;
        nxt_launched = 1'b1;
        div_dividend = ref_used_ff * m_ff;
        div_divisor  = n_ff;
        if (div_done) begin
          nxt_achieved = quo32;
          nxt_launched = 1'b0;
          nxt_state    = ST_APPLY;
        end
      end
      ST_QUARTZ: begin
        div_start    = !launched_ff;
        nxt_launched = 1'b1;
        div_dividend = {32'h0, QUARTZ_HZ};
        div_divisor  = {20'h0, quartz_divisor(qidx_ff)};
        if (div_done) begin
          nxt_launched = 1'b0;
          // Ties keep the faster rate found first.
          if (absdiff(quo32, target_ff) < absdiff(achieved_ff, target_ff)) begin
            nxt_achieved = quo32;
            nxt_qbest    = qidx_ff;
          end
          if (qidx_ff == QDIV_LAST) begin
            nxt_state = ST_APPLY;
          end else begin
            nxt_qidx = qidx_ff + 5'h01;
          end
        end
      end
      ST_APPLY: begin
        // Hardware factors change only here, once a full solution is known.
        nxt_cfg.enable       = synth_en_ff;
        nxt_cfg.ref_external = (ref_freq_ff != 32'h0);
        nxt_cfg.mult         = m_ff;
        nxt_cfg.div          = n_ff;
        nxt_qdiv             = quartz_divisor(qbest_ff);
        nxt_state            = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase

    // Connector: output only with internal clocking and no reference input in use.
    // Stay off until the solver has applied the internal reference as well.
    drive_ok    = clk_out_ff && !ext_sel_ff && (ref_freq_ff == 32'h0) &&
                  !cfg_ff.ref_external;
    nxt_conn_oe = drive_ok;
    nxt_conn_o  = drive_ok ? sample_clk : 1'b0;
    nxt_term_on = term_en_ff && !drive_ok;
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff   <= '0;
      aw_have_ff  <= 1'b0;
      wdata_ff    <= 32'h0;
      wstrb_ff    <= 4'h0;
      w_have_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= 2'b00;
      rvalid_ff   <= 1'b0;
      rresp_ff    <= 2'b00;
      rdata_ff    <= 32'h0;
      rate_req_ff <= RST_SAMPLE_RATE;
      synth_en_ff <= RST_SYNTH_EN;
      ext_sel_ff  <= RST_EXT_SEL;
      clk_out_ff  <= RST_CLK_OUT;
      term_en_ff  <= RST_TERM_EN;
      ref_freq_ff <= RST_REF_FREQ;
      pending_ff  <= 1'b1;
      state_ff    <= ST_IDLE;
      launched_ff <= 1'b0;
      target_ff   <= 32'h0;
      ref_used_ff <= 32'h0;
      n_ff        <= 32'h0;
      m_ff        <= 32'h0;
      cand_ff     <= 32'h0;
      qidx_ff     <= 5'h00;
      qbest_ff    <= 5'h00;
      achieved_ff <= 32'h0;
      cfg_ff      <= '0;
      qdiv_ff     <= 12'h001;
      conn_o_ff   <= 1'b0;
      conn_oe_ff  <= 1'b0;
      term_on_ff  <= 1'b0;
    end else begin
      awaddr_ff   <= nxt_awaddr;
      aw_have_ff  <= nxt_aw_have;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      w_have_ff   <= nxt_w_have;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      rvalid_ff   <= nxt_rvalid;
      rresp_ff    <= nxt_rresp;
      rdata_ff    <= nxt_rdata;
      rate_req_ff <= nxt_rate_req;
      synth_en_ff <= nxt_synth_en;
      ext_sel_ff  <= nxt_ext_sel;
      clk_out_ff  <= nxt_clk_out;
      term_en_ff  <= nxt_term_en;
      ref_freq_ff <= nxt_ref_freq;
      pending_ff  <= nxt_pending;
      state_ff    <= nxt_state;
      launched_ff <= nxt_launched;
      target_ff   <= nxt_target;
      ref_used_ff <= nxt_ref_used;
      n_ff        <= nxt_n;
      m_ff        <= nxt_m;
      cand_ff     <= nxt_cand;
      qidx_ff     <= nxt_qidx;
      qbest_ff    <= nxt_qbest;
      achieved_ff <= nxt_achieved;
      cfg_ff      <= nxt_cfg;
      qdiv_ff     <= nxt_qdiv;
      conn_o_ff   <= nxt_conn_o;
      conn_oe_ff  <= nxt_conn_oe;
      term_on_ff  <= nxt_term_on;
    end
  end

  // ==========================================================================
  // Outputs.
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign synth_cfg     = cfg_ff;
  assign quartz_div    = qdiv_ff;
  assign solver_busy   = (state_ff != ST_IDLE) || pending_ff;
  assign conn_o        = conn_o_ff;
  assign conn_oe       = conn_oe_ff;
  assign conn_term_on  = term_on_ff;

endmodule
`default_nettype wire

// ===== src/scg_pkg.sv
// Package: register map, constants and types of the sample clock generator.
package scg_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_SAMPLE_RATE = 16'h4e20;
  localparam logic [15:0] IDX_SYNTH_EN    = 16'h4e3e;
  localparam logic [15:0] IDX_EXT_SEL     = 16'h4e84;
  localparam logic [15:0] IDX_CLK_OUT     = 16'h4e8e;
  localparam logic [15:0] IDX_TERM_EN     = 16'h4e98;
  localparam logic [15:0] IDX_REF_FREQ    = 16'h4eac;
  localparam int          ADDR_W          = 18;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RST_SAMPLE_RATE = 32'h000186a0;
  localparam logic        RST_SYNTH_EN    = 1'h1;
  localparam logic        RST_EXT_SEL     = 1'h0;
  localparam logic        RST_CLK_OUT     = 1'h0;
  localparam logic        RST_TERM_EN     = 1'h0;
  localparam logic [31:0] RST_REF_FREQ    = 32'h00000000;

  // ==========================================================================
  // Frequencies in hertz.
  localparam logic [31:0] INT_REF_HZ  = 32'h02625a00;
  localparam logic [31:0] MIN_RATE_HZ = 32'h000003e8;
  localparam logic [31:0] REF_MIN_HZ  = 32'h000f4240;
  localparam logic [31:0] REF_MAX_HZ  = 32'h07735940;
  localparam logic [31:0] PFD_HZ      = 32'h000003e8;
  localparam logic [31:0] MAX_RATE_V0 = 32'h00030d40;
  localparam logic [31:0] MAX_RATE_V1 = 32'h0007a120;
  localparam logic [31:0] MAX_RATE_V2 = 32'h000f4240;
  localparam logic [31:0] MAX_RATE_V3 = 32'h002dc6c0;
  localparam logic [4:0]  QDIV_LAST   = 5'h10;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic        enable;
    logic        ref_external;
    logic [31:0] mult;
    logic [31:0] div;
  } scg_synth_cfg_s;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SYN_N = 6'h02,
    ST_SYN_M = 6'h04,
    ST_SYN_R = 6'h08,
    ST_QUARTZ = 6'h10,
    ST_APPLY = 6'h20
  } scg_state_e;

  function automatic logic [31:0] variant_max(input int v);
    case (v)
      0: variant_max = MAX_RATE_V0;
      1: variant_max = MAX_RATE_V1;
      2: variant_max = MAX_RATE_V2;
      default: variant_max = MAX_RATE_V3;
    endcase
  endfunction

  function automatic logic [11:0] quartz_divisor(input logic [4:0] idx);
    case (idx)
      5'h00: quartz_divisor = 12'h001;
      5'h01: quartz_divisor = 12'h002;
      5'h02: quartz_divisor = 12'h004;
      5'h03: quartz_divisor = 12'h008;
      5'h04: quartz_divisor = 12'h00a;
      5'h05: quartz_divisor = 12'h010;
      5'h06: quartz_divisor = 12'h014;
      5'h07: quartz_divisor = 12'h028;
      5'h08: quartz_divisor = 12'h032;
      5'h09: quartz_divisor = 12'h050;
      5'h0a: quartz_divisor = 12'h064;
      5'h0b: quartz_divisor = 12'h0c8;
      5'h0c: quartz_divisor = 12'h190;
      5'h0d: quartz_divisor = 12'h1f4;
      5'h0e: quartz_divisor = 12'h320;
      5'h0f: quartz_divisor = 12'h3e8;
      default: quartz_divisor = 12'h7d0;
    endcase
  endfunction

endpackage

// ===== src/scg_divider.sv
// Sequential unsigned restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module scg_divider #(
  parameter int DW = 64,
  parameter int VW = 32
) (
  // Clock and reset.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Operation.
  input  wire logic          start,
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  output logic               done,
  output logic [DW-1:0]      quotient
);

  logic [DW-1:0] quo_ff, nxt_quo;
  logic [VW:0]   rem_ff, nxt_rem;
  logic [VW-1:0] dvs_ff, nxt_dvs;
  logic [7:0]    cnt_ff, nxt_cnt;
  logic          busy_ff, nxt_busy;
  logic          done_ff, nxt_done;
  logic [VW:0]   trial;

  always_comb begin
    nxt_quo  = quo_ff;
    nxt_rem  = rem_ff;
    nxt_dvs  = dvs_ff;
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    trial    = {rem_ff[VW-1:0], quo_ff[DW-1]};
    if (start) begin
      nxt_quo  = dividend;
      nxt_rem  = '0;
      nxt_dvs  = divisor;
      nxt_cnt  = 8'(DW);
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      nxt_quo = {quo_ff[DW-2:0], 1'b0};
      if (trial >= {1'b0, dvs_ff}) begin
        nxt_rem    = trial - {1'b0, dvs_ff};
        nxt_quo[0] = 1'b1;
      end else begin
        nxt_rem = trial;
      end
      nxt_cnt = cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quo_ff  <= '0;
      rem_ff  <= '0;
      dvs_ff  <= '0;
      cnt_ff  <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      quo_ff  <= nxt_quo;
      rem_ff  <= nxt_rem;
      dvs_ff  <= nxt_dvs;
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign done     = done_ff;
  assign quotient = quo_ff;

endmodule
`default_nettype wire

// ===== testbench/scg_ref_source.sv
// Partner model: external reference source on the clock connector.
`timescale 1ns/1ps
`default_nettype none
module scg_ref_source #(
  parameter int HALF_NS = 50
) (
  // Connector pin triple.
  input  wire logic conn_o,
  input  wire logic conn_oe,
  output var logic  conn_i
);
  logic ref_clk;
  // ========
  // Free running 10 MHz source, matching the reference value the bench programs.
  initial begin
    ref_clk = 1'b0;
    forever #(HALF_NS) ref_clk = ~ref_clk;
  end
  // The board owns the wire only while it drives; otherwise the source shows.
  assign conn_i = conn_oe ? conn_o : ref_clk;
endmodule
`default_nettype wire

// ===== testbench/scg_clock_gen_checker.sv
// Checker: port assertions of the sample clock generator.
`timescale 1ns/1ps
`default_nettype none
module scg_checker
  import scg_pkg::*;
(
  // Clock and reset.
  input wire logic           aclk,
  input wire logic           aresetn,
  // Bus handshakes.
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic [1:0]     s_axi_bresp,
  // Clock hardware and connector.
  input wire logic           sample_clk,
  input wire scg_synth_cfg_s synth_cfg,
  input wire logic [11:0]    quartz_div,
  input wire logic           solver_busy,
  input wire logic           conn_o,
  input wire logic           conn_oe,
  input wire logic           conn_term_on
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========
  // Settled synthesizer state, valid only once the solver is idle.
  sequence s_int_idle;
    !solver_busy && synth_cfg.enable && !synth_cfg.ref_external;
  endsequence
  logic [10:0] busy_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !solver_busy) busy_cnt_ff <= 11'h000;
    else if (busy_cnt_ff != 11'h7ff) busy_cnt_ff <= busy_cnt_ff + 11'h001;
  end
  a_out_internal: assert property (conn_oe |-> !synth_cfg.ref_external)
    else $error("clock driven in reference mode");
  a_term_input: assert property (conn_term_on |-> !conn_oe)
    else $error("termination while driving");
  a_out_follows: assert property (conn_oe && $past(conn_oe) |-> conn_o == $past(sample_clk))
    else $error("connector not the sample clock");
  a_out_quiet: assert property (!conn_oe && !$past(conn_oe) |-> !conn_o)
    else $error("connector toggles undriven");
  a_div_legal: assert property (quartz_div inside {12'h001, 12'h002, 12'h004, 12'h008,
    12'h00a, 12'h010, 12'h014, 12'h028, 12'h032, 12'h050, 12'h064, 12'h0c8, 12'h190, 12'h1f4,
    12'h320, 12'h3e8, 12'h7d0})
    else $error("illegal quartz divisor");
  a_int_ref: assert property (s_int_idle |-> synth_cfg.div == 32'h00009c40)
    else $error("internal reference divider wrong");
  a_rate_range: assert property (s_int_idle |-> synth_cfg.mult inside {[1:3000]})
    else $error("multiplier outside rate range");
  a_solver_bound: assert property (busy_cnt_ff <= 11'h5dc)
    else $error("solver hangs");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind scg_clock_gen scg_checker u_chk (.*);
`default_nettype wire

// ===== testbench/sample_clock_generation_tb_top.sv
// Testbench: register scenarios for the sample clock generator.
`timescale 1ns/1ps
`default_nettype none
module sample_clock_generation_tb_top;
  import scg_pkg::*;
  logic              aclk, aresetn, sample_clk, conn_i, conn_o, conn_oe, conn_term_on;
  logic              solver_busy, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [11:0]       quartz_div;
  scg_synth_cfg_s    synth_cfg;
  int                miscompares, num_checks, i;
  logic [31:0]       sreq[4] = '{32'h0012d687, 32'h000001f4, 32'h004c4b40, 32'h000003e8};
  logic [31:0]       sexp[4] = '{32'h0012d838, 32'h000003e8, 32'h002dc6c0, 32'h000003e8};
  logic [31:0]       qreq[4] = '{32'h0005265c, 32'h0012d687, 32'h000003e8, 32'h002dc6c0};
  logic [31:0]       qexp[4] = '{32'h0005b8d8, 32'h0016e360, 32'h000005dc, 32'h002dc6c0};
  logic [11:0]       qdiv[4] = '{12'h008, 12'h002, 12'h7d0, 12'h001};
  scg_clock_gen dut (.*);
  scg_ref_source u_src (.conn_o(conn_o), .conn_oe(conn_oe), .conn_i(conn_i));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) sample_clk <= ~sample_clk;
  // ========
  // Bus tasks and checks.
  task automatic results();
    $display("checks %0d errors %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    results();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) timeout();
    chk(s_axi_bresp, r);
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) timeout();
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask
  // Waits out the solver; readback is stale while it runs.
  task automatic settle();
    int n;
    repeat (2) @(posedge aclk);
    for (n = 0; n < 3000 && solver_busy !== 1'b0; n++) @(posedge aclk);
    if (n == 3000) timeout();
    repeat (2) @(posedge aclk);
  endtask
  // ========
  // Main sequence.
  initial begin
    {aresetn, sample_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    rd(IDX_SAMPLE_RATE, 32'h000186a0);
    rd(IDX_SYNTH_EN, 32'h00000001);
    rd(IDX_REF_FREQ, 32'h00000000);
    chk(synth_cfg.mult, 32'h00000064);
    for (i = 0; i < 4; i++) begin
      wr(IDX_SAMPLE_RATE, sreq[i]);
      settle();
      rd(IDX_SAMPLE_RATE, sexp[i]);
    end
    wr(IDX_SYNTH_EN, 32'h00000000);
    settle();
    for (i = 0; i < 4; i++) begin
      wr(IDX_SAMPLE_RATE, qreq[i]);
      settle();
      rd(IDX_SAMPLE_RATE, qexp[i]);
      chk(quartz_div, qdiv[i]);
      chk(synth_cfg.enable, 32'h00000000);
    end
    wr(IDX_SYNTH_EN, 32'h00000001);
    wr(IDX_REF_FREQ, 32'h00989680);
    wr(IDX_SAMPLE_RATE, sreq[0]);
    settle();
    rd(IDX_SAMPLE_RATE, sexp[0]);
    chk(synth_cfg.ref_external, 32'h00000001);
    chk(synth_cfg.div, 32'h00002710);
    wr(IDX_REF_FREQ, 32'h07735941);
    wr(IDX_REF_FREQ, 32'h000f423f);
    rd(IDX_REF_FREQ, 32'h00989680);
    wr(IDX_REF_FREQ, 32'h07735940);
    rd(IDX_REF_FREQ, 32'h07735940);
    wr(IDX_CLK_OUT, 32'h00000001);
    wr(IDX_TERM_EN, 32'h00000001);
    chk(conn_oe, 32'h00000000);
    chk(conn_term_on, 32'h00000001);
    wr(IDX_REF_FREQ, 32'h00000000);
    settle();
    chk(conn_oe, 32'h00000001);
    chk(conn_term_on, 32'h00000000);
    wr(IDX_EXT_SEL, 32'h00000001);
    chk(conn_oe, 32'h00000000);
    wr(16'h0000, 32'h00000001, 2'h2);
    rd(16'h0000, 32'h00000000, 2'h2);
    results();
  end
endmodule
`default_nettype wire
